/* File: npep_params.svh */
// Purpose: timing counts, addresses, command codes and field layout for the
//          program/erase/protect sequencer and its programmer end.
// Assumes: 10 MHz system clock on both ends.
// Notes:   definitions only.
`ifndef NPEP_PARAMS_SVH
`define NPEP_PARAMS_SVH

`define NPEP_CLK_NS      100
`define NPEP_HALF        4
`define NPEP_TDLY2_NS    1000
`define NPEP_TDLY2_CYC   ((`NPEP_TDLY2_NS + `NPEP_CLK_NS - 1) / `NPEP_CLK_NS)
`define NPEP_DISCHARGE_DELAY_US     100
`define NPEP_DISCHARGE_DELAY_CYC    ((`NPEP_DISCHARGE_DELAY_US * 1000 + `NPEP_CLK_NS - 1) / `NPEP_CLK_NS)
`define NPEP_PROGRAM_TIME_US    2000
`define NPEP_PROGRAM_TIME_CYC   ((`NPEP_PROGRAM_TIME_US * 1000 + `NPEP_CLK_NS - 1) / `NPEP_CLK_NS)
`define NPEP_ERASE_TIME_US     10000
`define NPEP_ERASE_TIME_CYC    ((`NPEP_ERASE_TIME_US * 1000 + `NPEP_CLK_NS - 1) / `NPEP_CLK_NS)
`define NPEP_TMR_W       24

`define NPEP_OP_LOAD     4'h2
`define NPEP_OP_READ     4'h4
`define NPEP_OP_INC      4'h6
`define NPEP_OP_BEGIN    4'h8
`define NPEP_OP_END      4'hE
`define NPEP_OP_ERASE    4'h9

`define NPEP_CFG_ADDR    10'h3FF
`define NPEP_TRIM_ADDR   10'h1FF
`define NPEP_ID0_ADDR    10'h200
`define NPEP_BKUP_ADDR   10'h204
`define NPEP_CP_LO       10'h040
`define NPEP_CFG_CP_BIT  3
`define NPEP_CFG_IMPL    12'h01F
`define NPEP_ERASED      12'hFFF
`endif

/* File: npep_pkg.sv */
// Purpose: shared types of the sequencer and programmer ends.
// Assumes: nothing beyond the parameter header.
// Notes:   Gray codes along the host path from idle through data to wait.
`default_nettype none
package npep_pkg;
    typedef enum logic [1:0] {D_CMD = 2'h0, D_DATA = 2'h1, D_ERASE = 2'h3} npep_dst_t;
    typedef enum logic [2:0] {H_IDLE = 3'h0, H_CMD = 3'h1, H_GAP = 3'h3,
                              H_DATA = 3'h2, H_WAIT = 3'h6} npep_hst_t;
    typedef enum logic [1:0] {RG_USER = 2'h0, RG_ID = 2'h1, RG_CFG = 2'h2,
                              RG_NONE = 2'h3} npep_rgn_t;
endpackage
`default_nettype wire

/* File: npep_link_if.sv */
// Purpose: two-pin serial programming link between programmer and device.
// Assumes: the data pin is pulled high when nobody drives it.
// Notes:   the only place where the shared data wire level is resolved.
`default_nettype none
interface npep_link_if;
    logic pclk;
    logic dat_h_o;
    logic dat_h_oe;
    logic dat_d_o;
    logic dat_d_oe;
    logic dat;
    // Device wins whenever it drives; programmer only while the device has released the pin
    assign dat = dat_d_oe ? dat_d_o : (dat_h_oe ? dat_h_o : 1'b1);
    modport host (output pclk, output dat_h_o, output dat_h_oe, input dat);
    modport dev  (input pclk, input dat, output dat_d_o, output dat_d_oe);
endinterface
`default_nettype wire

/* File: npep_sync.sv */
// Purpose: two-flop synchroniser with edge detection on the settled copy.
// Assumes: inputs are asynchronous to i_clk.
// Notes:   edges are seen two to three cycles after the pin moves.
`default_nettype none
module npep_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_fall
);
    logic [W-1:0] m1_q;
    logic [W-1:0] m2_q;
    logic [W-1:0] m3_q;

    // First stage feeds only the second, to contain metastability
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            m1_q <= '0;
            m2_q <= '0;
            m3_q <= '0;
        end
        else
        begin
            m1_q <= i_async;
            m2_q <= m1_q;
            m3_q <= m2_q;
        end
    end

    // Edges taken from settled stages only
    assign o_level = m2_q;
    assign o_rise  = m2_q & ~m3_q;
    assign o_fall  = ~m2_q & m3_q;
endmodule
`default_nettype wire

/* File: npep_dev.sv */
// Purpose: device end: command decode, word programming, bulk erase,
//          code-protected read-out and configuration word.
// Assumes: reset is programming-mode entry; link pins are asynchronous.
// Notes:   memory has no reset; erase walks it during the erase time.
`default_nettype none
`include "npep_params.svh"

module npep_dev
    import npep_pkg::*;
#(
    parameter int unsigned ERASE_CYC = `NPEP_ERASE_TIME_CYC
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    npep_link_if.dev         LINK,
    output logic      [11:0] O_CONFIG,
    output logic             O_PROG_ACTIVE,
    output logic             O_ERASE_BUSY,
    output logic      [9:0]  O_ADDR
);
    logic [1:0]  s_lvl;
    logic [1:0]  s_rise;
    logic [1:0]  s_fall;
    npep_dst_t   st_q;
    logic [3:0]  cnt_q;
    logic [15:0] sh_q;
    logic [3:0]  op_q;
    logic [5:0]  c6;
    logic        cmd_done;
    logic        cmd_ok;
    logic        data_done;
    logic        prog_wr;
    logic        loaded_q;
    logic [11:0] data_q;
    logic        cfg_acc_q;
    logic        ers_all_q;
    logic [`NPEP_TMR_W-1:0] ers_cnt_q;
    logic [13:0] rword_q;
    logic [11:0] rd_w;
    logic [11:0] mem [0:511];
    logic [11:0] idw [0:4];

    // Address to area decode, shared by read and write paths
    function automatic npep_rgn_t rgn(input logic [9:0] a, input logic acc);
        if (a < `NPEP_ID0_ADDR)
            return RG_USER;
        else if (a <= `NPEP_BKUP_ADDR)
            return RG_ID;
        else if (a == `NPEP_CFG_ADDR && acc)
            return RG_CFG;
        else
            return RG_NONE;
    endfunction

    npep_sync #(
        .W (2)
    ) u_sync (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_async ({LINK.dat, LINK.pclk}),
        .o_level (s_lvl),
        .o_rise  (s_rise),
        .o_fall  (s_fall)
    );

    assign c6        = {s_lvl[1], sh_q[15:11]};
    assign cmd_done  = (st_q == D_CMD) && s_fall[0] && (cnt_q == 4'h5);
    // Only end is heard while the programming voltage is up
    assign cmd_ok    = cmd_done && (!O_PROG_ACTIVE || c6[3:0] == `NPEP_OP_END);
    assign data_done = (st_q == D_DATA) && s_fall[0] && (cnt_q == 4'hF);
    assign prog_wr   = cmd_ok && (c6[3:0] == `NPEP_OP_BEGIN) && loaded_q;

    // Command and data phase sequencing
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            st_q         <= D_CMD;
            cnt_q        <= 4'h0;
            sh_q         <= 16'h0000;
            op_q         <= 4'h0;
            O_ERASE_BUSY <= 1'b0;
            ers_cnt_q    <= '0;
            ers_all_q    <= 1'b0;
        end
        else
        begin
            case (st_q)
                D_CMD:
                begin
                    if (s_fall[0])
                    begin
                        sh_q  <= {s_lvl[1], sh_q[15:1]};
                        cnt_q <= (cnt_q == 4'h5) ? 4'h0 : cnt_q + 4'h1;
                    end
                    if (cmd_ok)
                    begin
                        op_q <= c6[3:0];
                        if (c6[3:0] == `NPEP_OP_LOAD || c6[3:0] == `NPEP_OP_READ)
                            st_q <= D_DATA;
                        else if (c6[3:0] == `NPEP_OP_ERASE)
                        begin
                            st_q         <= D_ERASE;
                            O_ERASE_BUSY <= 1'b1;
                            ers_cnt_q    <= `NPEP_TMR_W'(ERASE_CYC - 1);
                            ers_all_q    <= (O_ADDR == `NPEP_ID0_ADDR);
                        end
                    end
                end
                D_DATA:
                begin
                    if (s_fall[0])
                    begin
                        sh_q  <= {s_lvl[1], sh_q[15:1]};
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'hF)
                            st_q <= D_CMD;
                    end
                end
                D_ERASE:
                begin
                    cnt_q     <= 4'h0;
                    ers_cnt_q <= ers_cnt_q - 1'b1;
                    if (ers_cnt_q == '0)
                    begin
                        st_q         <= D_CMD;
                        O_ERASE_BUSY <= 1'b0;
                    end
                end
                default:
                begin
                    st_q  <= D_CMD;
                    cnt_q <= 4'h0;
                end
            endcase
        end
    end

    // Load flag and programming state; load cannot coincide with begin
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            loaded_q      <= 1'b0;
            data_q        <= 12'h000;
            O_PROG_ACTIVE <= 1'b0;
        end
        else
        begin
            if (data_done && op_q == `NPEP_OP_LOAD)
            begin
                loaded_q <= 1'b1;
                data_q   <= sh_q[13:2];   // Bits after start; top two ignored
            end
            else if (prog_wr)
                loaded_q <= 1'b0;
            if (prog_wr)
                O_PROG_ACTIVE <= 1'b1;
            else if (cmd_ok && c6[3:0] == `NPEP_OP_END)
                O_PROG_ACTIVE <= 1'b0;
        end
    end

    // Address counter and configuration word window
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            O_ADDR    <= `NPEP_CFG_ADDR;
            cfg_acc_q <= 1'b1;
        end
        else if (cmd_ok && c6[3:0] == `NPEP_OP_INC)
        begin
            O_ADDR    <= O_ADDR + 10'h001;   // Wraps top to zero, never decrements
            cfg_acc_q <= 1'b0;
        end
    end

    // Program memory: erase walk has priority over word writes
    always_ff @(posedge I_CLK)
    begin
        if (st_q == D_ERASE)
            mem[ers_cnt_q[8:0]] <= `NPEP_ERASED;
        else if (prog_wr && rgn(O_ADDR, cfg_acc_q) == RG_USER)
            // ones can only fall to zero
            mem[O_ADDR[8:0]] <= mem[O_ADDR[8:0]] & data_q;
    end

    // ID, backup trim and config word storage
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            for (int i = 0; i < 5; i++)
                idw[i] <= `NPEP_ERASED;
            O_CONFIG <= `NPEP_ERASED;
        end
        else if (st_q == D_ERASE)
        begin
            O_CONFIG <= `NPEP_ERASED;
            // IDs and backup only in full erase
            if (ers_all_q)
                for (int i = 0; i < 5; i++)
                    idw[i] <= `NPEP_ERASED;
        end
        else if (prog_wr)
        begin
            if (rgn(O_ADDR, cfg_acc_q) == RG_ID)
                idw[O_ADDR[2:0]] <= idw[O_ADDR[2:0]] & data_q;
            else if (rgn(O_ADDR, cfg_acc_q) == RG_CFG)
                O_CONFIG <= (O_CONFIG & data_q) | ~`NPEP_CFG_IMPL;
        end
    end

    // Read word with protection masking
    always_comb
    begin
        case (rgn(O_ADDR, cfg_acc_q))
            RG_USER:
            begin
                // mask middle of user space only
                if (!O_CONFIG[`NPEP_CFG_CP_BIT] && O_ADDR >= `NPEP_CP_LO
                    && O_ADDR < `NPEP_TRIM_ADDR)
                    rd_w = 12'h000;
                else
                    rd_w = mem[O_ADDR[8:0]];
            end
            RG_ID:   rd_w = idw[O_ADDR[2:0]];
            RG_CFG:  rd_w = O_CONFIG;
            default: rd_w = `NPEP_ERASED;
        endcase
    end

    // Read-out driver: rising edges of data clocks 2 to 15
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            rword_q       <= 14'h0000;
            LINK.dat_d_o  <= 1'b0;
            LINK.dat_d_oe <= 1'b0;
        end
        else
        begin
            if (cmd_ok && c6[3:0] == `NPEP_OP_READ)
                rword_q <= {2'h0, rd_w};   // Top two bits read as zero
            if (st_q != D_DATA || op_q != `NPEP_OP_READ)
                LINK.dat_d_oe <= 1'b0;
            else if (s_rise[0])
            begin
                LINK.dat_d_oe <= (cnt_q >= 4'h1) && (cnt_q <= 4'hE);
                LINK.dat_d_o  <= rword_q[cnt_q - 4'h1];
            end
        end
    end
endmodule
`default_nettype wire

/* File: npep_host.sv */
// Purpose: programmer end: makes the link clock, sends commands and data,
//          keeps the delays the device relies on.
// Assumes: user waits for O_BUSY low before each request.
// Notes:   begin is followed automatically by end after the program time.
`default_nettype none
`include "npep_params.svh"
module npep_host
    import npep_pkg::*;
#(
    parameter int unsigned PROG_CYC  = `NPEP_PROGRAM_TIME_CYC,
    parameter int unsigned ERASE_CYC = `NPEP_ERASE_TIME_CYC
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_REQ,
    input  wire logic [5:0]  I_CMD,
    input  wire logic [11:0] I_DATA,
    npep_link_if.host        LINK,
    output logic             O_BUSY,
    output logic      [11:0] O_RDATA,
    output logic             O_RVALID,
    output logic             O_REFUSED,
    output logic      [11:0] O_TRIM,
    output logic      [11:0] O_BACKUP
);
    npep_hst_t   st_q;
    logic [15:0] sh_q;
    logic [3:0]  bit_q;
    logic [2:0]  ph_q;
    logic [`NPEP_TMR_W-1:0] wait_q;
    logic [5:0]  cmd_q;
    logic [11:0] wd_q;
    logic        end_pend_q;
    logic        loaded_q;
    logic [9:0]  amir_q;
    logic [13:0] rsh_q;
    logic        dat_s;
    logic        last_bit;

    npep_sync #(
        .W (1)
    ) u_sync (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_async (LINK.dat),
        .o_level (dat_s),
        .o_rise  (),
        .o_fall  ()
    );

    assign last_bit = (ph_q == 3'(2 * `NPEP_HALF - 1))
                    && (bit_q == ((st_q == H_CMD) ? 4'h5 : 4'hF));

    // Sequencer with bit timing; clock divided from I_CLK
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            st_q <= H_IDLE; sh_q <= 16'h0000; bit_q <= 4'h0; ph_q <= 3'h0;
            wait_q <= '0; cmd_q <= 6'h00; wd_q <= 12'h000; end_pend_q <= 1'b0;
            loaded_q <= 1'b0; amir_q <= `NPEP_CFG_ADDR; rsh_q <= 14'h0000;
            O_BUSY <= 1'b0; O_RDATA <= 12'h000; O_RVALID <= 1'b0;
            O_REFUSED <= 1'b0; O_TRIM <= `NPEP_ERASED; O_BACKUP <= `NPEP_ERASED;
            LINK.pclk <= 1'b0; LINK.dat_h_o <= 1'b0; LINK.dat_h_oe <= 1'b1;
        end
        else
        begin
            O_RVALID  <= 1'b0;
            O_REFUSED <= 1'b0;
            case (st_q)
                H_IDLE:
                begin
                    LINK.dat_h_oe <= 1'b1;
                    LINK.dat_h_o  <= 1'b0;
                    if (I_REQ)
                    begin
                        if (I_CMD[3:0] == `NPEP_OP_BEGIN && !loaded_q)
                            O_REFUSED <= 1'b1;
                        else
                        begin
                            cmd_q <= I_CMD; wd_q <= I_DATA; sh_q <= {10'h000, I_CMD};
                            bit_q <= 4'h0; ph_q <= 3'h0; O_BUSY <= 1'b1; st_q <= H_CMD;
                        end
                    end
                end
                H_CMD, H_DATA:
                begin
                    ph_q <= ph_q + 3'h1;
                    if (ph_q == 3'h0)
                    begin
                        // data set at rise, device takes it at fall
                        LINK.pclk     <= 1'b1;
                        LINK.dat_h_o  <= sh_q[0];
                        LINK.dat_h_oe <= !(st_q == H_DATA && cmd_q[3:0] == `NPEP_OP_READ);
                        if (st_q == H_DATA && bit_q >= 4'h2)
                            rsh_q <= {dat_s, rsh_q[13:1]};   // Bit driven one clock ago
                    end
                    if (ph_q == 3'(`NPEP_HALF))
                        LINK.pclk <= 1'b0;
                    if (ph_q == 3'(2 * `NPEP_HALF - 1))
                    begin
                        ph_q  <= 3'h0;
                        sh_q  <= {1'b0, sh_q[15:1]};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (last_bit && st_q == H_CMD)
                    begin
                        bit_q <= 4'h0;
                        case (cmd_q[3:0])
                            `NPEP_OP_LOAD, `NPEP_OP_READ:
                            begin
                                st_q   <= H_GAP;
                                sh_q   <= {3'h0, wd_q, 1'b0};   // Start, 14 data, stop
                                wait_q <= `NPEP_TMR_W'(`NPEP_TDLY2_CYC - 1);
                            end
                            `NPEP_OP_BEGIN:
                            begin
                                st_q <= H_WAIT; end_pend_q <= 1'b1; loaded_q <= 1'b0;
                                wait_q <= `NPEP_TMR_W'(PROG_CYC - 1);
                            end
                            `NPEP_OP_END:
                            begin
                                st_q   <= H_WAIT;
                                wait_q <= `NPEP_TMR_W'(`NPEP_DISCHARGE_DELAY_CYC - 1);
                            end
                            `NPEP_OP_ERASE:
                            begin
                                st_q   <= H_WAIT;
                                wait_q <= `NPEP_TMR_W'(ERASE_CYC - 1);
                            end
                            default:
                            begin
                                if (cmd_q[3:0] == `NPEP_OP_INC)
                                    amir_q <= amir_q + 10'h001;
                                st_q   <= H_WAIT;
                                wait_q <= `NPEP_TMR_W'(`NPEP_TDLY2_CYC - 1);
                            end
                        endcase
                    end
                    else if (last_bit)
                    begin
                        st_q   <= H_WAIT;
                        wait_q <= `NPEP_TMR_W'(`NPEP_TDLY2_CYC - 1);
                        if (cmd_q[3:0] == `NPEP_OP_LOAD)
                            loaded_q <= 1'b1;
                        else
                        begin
                            O_RDATA  <= rsh_q[11:0];
                            O_RVALID <= 1'b1;
                            // keep trim words seen in reads
                            if (amir_q == `NPEP_TRIM_ADDR)
                                O_TRIM <= rsh_q[11:0];
                            if (amir_q == `NPEP_BKUP_ADDR)
                                O_BACKUP <= rsh_q[11:0];
                        end
                    end
                end
                H_GAP, H_WAIT:
                begin
                    wait_q <= wait_q - 1'b1;
                    if (wait_q == '0)
                    begin
                        ph_q <= 3'h0;
                        if (st_q == H_GAP)
                            st_q <= H_DATA;
                        else if (end_pend_q)
                        begin
                            end_pend_q <= 1'b0;
                            cmd_q <= {2'h0, `NPEP_OP_END};
                            sh_q  <= {12'h000, `NPEP_OP_END};
                            st_q  <= H_CMD;
                        end
                        else
                        begin
                            st_q   <= H_IDLE;
                            O_BUSY <= 1'b0;
                        end
                    end
                end
                default:
                    st_q <= H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: npep_link_checker.sv */
// Purpose: link checker beside the two ends.
// Assumes: link clock made from 8 system clocks.
// Notes:   sees only link wires, so both ends are judged.
`default_nettype none
module npep_link_checker (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic pclk,
    input wire logic dat_h_o,
    input wire logic dat_h_oe,
    input wire logic dat_d_oe
);
    default clocking @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // One high phase of the link clock, then low
    sequence s_high;
        pclk [*4] ##1 !pclk;
    endsequence
    a_pclk_high: assert property ($rose(pclk) |-> s_high)
        else $error("link clock high phase wrong");
    a_pclk_low: assert property ($fell(pclk) |-> !pclk [*4])
        else $error("link clock low phase short");
    a_pclk_period: assert property ($rose(pclk) |=> !$rose(pclk) [*7])
        else $error("link clock period short");
    // Setup: data must not move on the latching edge
    a_dat_setup: assert property ($fell(pclk) && dat_h_oe |-> $stable(dat_h_o))
        else $error("data moved at falling clock");
    a_no_clash: assert property (!(dat_d_oe && dat_h_oe))
        else $error("both ends drive data");
    a_drive_rise: assert property ($rose(dat_d_oe) |-> $past(pclk, 2))
        else $error("device drove off a rising edge");
    // Device drives 14 bits, then releases at the stop cycle
    a_drive_window: assert property ($rose(dat_d_oe) |-> ##[110:114] $fell(dat_d_oe))
        else $error("read drive window wrong");
    a_entry_idle: assert property ($fell(I_RST) |-> !pclk && dat_h_oe && !dat_d_oe)
        else $error("link not idle after entry");
endmodule
`default_nettype wire

/* File: nvm_program_erase_protect_tb_top.sv */
// Purpose: bench joining programmer and sequencer over the link.
// Assumes: short program and erase counts.
// Notes:   memory and config kept in a plain model.
`default_nettype none
`include "npep_params.svh"
module nvm_program_erase_protect_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        req = 1'b0;
    logic [5:0]  cmd = 6'h00;
    logic [11:0] wd = 12'h000;
    logic [11:0] rdata, cfg, lrd, cm, d, trim;
    logic [9:0]  addr;
    logic        busy, rv, rf;
    logic [31:0] rng = 32'h6FC13ACC;
    logic [11:0] mem [0:511];
    int          n_fail = 0;
    int          n_checks = 0;
    int          n_ref = 0;
    npep_link_if i_npep_link_if ();
    npep_dev #(.ERASE_CYC(600)) i_npep_dev (.I_CLK(clk), .I_RST(rst),
        .LINK(i_npep_link_if), .O_CONFIG(cfg), .O_PROG_ACTIVE(),
        .O_ERASE_BUSY(), .O_ADDR(addr));
    npep_host #(.PROG_CYC(20), .ERASE_CYC(600)) i_npep_host (.I_CLK(clk),
        .I_RST(rst), .I_REQ(req), .I_CMD(cmd), .I_DATA(wd),
        .LINK(i_npep_link_if), .O_BUSY(busy), .O_RDATA(rdata), .O_RVALID(rv),
        .O_REFUSED(rf), .O_TRIM(trim), .O_BACKUP());
    npep_link_checker i_npep_link_checker (.I_CLK(clk), .I_RST(rst),
        .pclk(i_npep_link_if.pclk), .dat_h_o(i_npep_link_if.dat_h_o),
        .dat_h_oe(i_npep_link_if.dat_h_oe), .dat_d_oe(i_npep_link_if.dat_d_oe));
    always #50 clk = ~clk;
    // Latch read words and count refusals, both one-cycle pulses
    always @(posedge clk)
    begin
        if (rv === 1'b1)
            lrd <= rdata;
        if (rf === 1'b1)
            n_ref <= n_ref + 1;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_sim();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Random don't-care top bits show the device decodes the low four only
    task automatic op(input logic [3:0] c, input logic [11:0] v);
        int i;
        rng = lfsr(rng);
        @(negedge clk);
        cmd = {rng[5:4], c};
        wd = v;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        repeat (2) @(negedge clk);
        for (i = 0; i < 3000 && busy !== 1'b0; i++)
            @(negedge clk);
        if (i == 3000)
        begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic prg(input logic [11:0] v);
        op(`NPEP_OP_LOAD, v);
        op(`NPEP_OP_BEGIN, 12'h000);
    endtask
    initial
    begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk({2'h0, addr}, 12'h3FF);
        op(`NPEP_OP_ERASE, 12'h000);
        for (int a = 0; a < 512; a++)
            mem[a] = 12'hFFF;
        cm = 12'hFFF;
        chk(cfg, cm);
        d = {7'h7F, rng[4], 1'b0, rng[2:0]};
        prg(d);
        cm = cm & d;
        chk(cfg, cm);
        prg(12'hFFF);
        chk(cfg, cm);
        op(`NPEP_OP_BEGIN, 12'h000);
        chk(12'(n_ref), 12'h001);
        op(`NPEP_OP_INC, 12'h000);
        chk({2'h0, addr}, 12'h000);
        // Two writes to one word: no erase, so bits only clear
        for (int a = 0; a <= 64; a++)
        begin
            if (a % 64 == 0)
            begin
                repeat (2)
                begin
                    rng = lfsr(rng);
                    prg(rng[11:0]);
                    mem[a] = mem[a] & rng[11:0];
                end
                op(`NPEP_OP_READ, 12'h000);
                chk(lrd, (a == 0) ? mem[a] : 12'h000);
            end
            op(`NPEP_OP_INC, 12'h000);
        end
        $display("program and protect test done");
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        op(`NPEP_OP_ERASE, 12'h000);
        chk(cfg, 12'hFFF);
        op(`NPEP_OP_INC, 12'h000);
        op(`NPEP_OP_READ, 12'h000);
        chk(lrd, 12'hFFF);
        $display("erase test done");
        // Protect again, then walk to the first ID word past the masked edge
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        prg(12'hFF7);
        chk(cfg, 12'hFF7);
        for (int a = 0; a < 513; a++)
        begin
            op(`NPEP_OP_INC, 12'h000);
            if (a >= 510)
            begin
                // ID word stays writable under protection
                if (a == 512)
                    prg(12'hFF5);
                op(`NPEP_OP_READ, 12'h000);
                chk(lrd, (a == 510) ? 12'h000 : ((a == 511) ? 12'hFFF : 12'hFF5));
                if (a == 511)
                    chk(trim, 12'hFFF);
            end
        end
        // Counter at first ID word: the erase reaches the IDs as well
        op(`NPEP_OP_ERASE, 12'h000);
        chk(cfg, 12'hFFF);
        op(`NPEP_OP_READ, 12'h000);
        chk(lrd, 12'hFFF);
        $display("full erase test done");
        end_sim();
    end
endmodule
`default_nettype wire
